// [shared/ipcfg_pkg.sv]
// input path configuration register bank: offsets, fields, reset values
// assumes a 16-bit word control port with word addresses as printed
// Notes on behaviour
// - shared 3-bit cutoff select, resets to 010
// - per-channel filter enable bit 15, resets 0
// - right control holds only enable and gain
// - pair oversample rate bits 14:13, resets 01
// - noise-cancel source forces 3.072MHz mic clock
// - level reference select bits 12:11, resets 00
// - pair mode bits 10:9, code 11 reserved
// - gain code bits 7:1, resets 40h
// - sample delay bits 5:0, resets 00h
// - pair two mirrors pair one left control and delay fields only; its right channel has no registers here
// - one mode field drives both channels
package ipcfg_pkg;
  localparam int IPCFG_AW = 10;
  localparam int IPCFG_DW = 16;
  localparam logic [9:0] OFS_CUTOFF = 10'h30C;
  localparam logic [9:0] OFS_P1L_CTL = 10'h310;
  localparam logic [9:0] OFS_P1L_DLY = 10'h312;
  localparam logic [9:0] OFS_P1R_CTL = 10'h314;
  localparam logic [9:0] OFS_P1R_DLY = 10'h316;
  localparam logic [9:0] OFS_P2L_CTL = 10'h318;
  localparam logic [9:0] OFS_P2L_DLY = 10'h31A;
  localparam int BIT_FILTER_ON = 15;
  localparam int POS_OSR = 13;
  localparam int POS_REF = 11;
  localparam int POS_KIND = 9;
  localparam int POS_GAIN = 1;
  localparam int POS_DLY = 0;
  localparam logic [15:0] MASK_CUTOFF = 16'h0007;
  localparam logic [15:0] MASK_LEFT_CTL = 16'hFEFE;
  localparam logic [15:0] MASK_RIGHT_CTL = 16'h80FE;
  localparam logic [15:0] MASK_DLY = 16'h003F;
  localparam logic [15:0] RST_CUTOFF = 16'h0002;
  localparam logic [15:0] RST_LEFT_CTL = 16'h2080;
  localparam logic [15:0] RST_RIGHT_CTL = 16'h0080;
  localparam logic [15:0] RST_DLY = 16'h0000;
  localparam logic [1:0] OSR_FORCED = 2'h1;
  typedef enum logic [1:0] {
    IPCFG_DIFF = 2'h0,
    IPCFG_SINGLE = 2'h1,
    IPCFG_DMIC = 2'h2,
    IPCFG_RSVD = 2'h3
  } ipcfg_kind_e;
  typedef struct packed {
    logic [1:0] oversample_rate;
    logic [1:0] level_reference;
    ipcfg_kind_e input_kind;
    logic left_filter_on;
    logic right_filter_on;
    logic [6:0] left_gain_code;
    logic [6:0] right_gain_code;
    logic [5:0] left_sample_delay;
    logic [5:0] right_sample_delay;
    logic left_is_digital;
    logic right_is_digital;
  } ipcfg_pair_s;
endpackage

// [rtl/ipcfg_reg16.sv]
// one 16-bit masked configuration register
// assumes write strobe synchronous to sys_clk
`timescale 1ns/1ps
module ipcfg_reg16
  import ipcfg_pkg::*;
#(
  parameter logic [15:0] MASK = 16'hFFFF,
  parameter logic [15:0] RESET_VALUE = 16'h0000
)
(
  // system
  input wire logic sys_clk,
  input wire logic reset_n,
  // write
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // value
  output logic [15:0] value
);
  logic [15:0] value_reg;
  logic [15:0] value_next;

  always_comb
  begin
    value_next = value_reg;
    if (wr_en)
    begin
      value_next = wr_data & MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      value_reg <= RESET_VALUE & MASK;
    end
    else
    begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;
endmodule // ipcfg_reg16

// [rtl/ipcfg_regs.sv]
// input path configuration register bank for pairs one and two
// assumes a synchronous word-addressed control port on sys_clk
`timescale 1ns/1ps
module ipcfg_regs
  import ipcfg_pkg::*;
(
  // system
  input wire logic sys_clk,
  input wire logic reset_n,
  // control port
  input wire logic [IPCFG_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [IPCFG_DW-1:0] reg_wdata,
  output logic [IPCFG_DW-1:0] reg_rdata,
  output logic reg_hit,
  // noise cancel source selects, pair two right filter enable input
  input wire logic pair1_noise_cancel_src,
  input wire logic pair2_noise_cancel_src,
  input wire logic [1:0] pair2_right_filter_gain_unused,
  // decoded fields
  output logic [2:0] shared_cutoff_select,
  output ipcfg_pair_s pair1_cfg,
  output ipcfg_pair_s pair2_cfg,
  output logic [1:0] pair1_clock_rate,
  output logic [1:0] pair2_clock_rate
);
  localparam int NREG = 7;
  localparam logic [15:0] MSK [NREG] = '{MASK_CUTOFF, MASK_LEFT_CTL,
    MASK_DLY, MASK_RIGHT_CTL, MASK_DLY, MASK_LEFT_CTL, MASK_DLY};
  localparam logic [15:0] RST [NREG] = '{RST_CUTOFF, RST_LEFT_CTL,
    RST_DLY, RST_RIGHT_CTL, RST_DLY, RST_LEFT_CTL, RST_DLY};

  logic [15:0] val [NREG];
  logic [NREG-1:0] sel;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic hit_reg;
  logic hit_next;

  // address match
  function automatic logic [NREG-1:0] decode(input logic [9:0] a);
    logic [NREG-1:0] d;
    d = '0;
    if (a == OFS_CUTOFF)
    begin
      d[0] = 1'b1;
    end
    else if (a == OFS_P1L_CTL)
    begin
      d[1] = 1'b1;
    end
    else if (a == OFS_P1L_DLY)
    begin
      d[2] = 1'b1;
    end
    else if (a == OFS_P1R_CTL)
    begin
      d[3] = 1'b1;
    end
    else if (a == OFS_P1R_DLY)
    begin
      d[4] = 1'b1;
    end
    else if (a == OFS_P2L_CTL)
    begin
      d[5] = 1'b1;
    end
    else if (a == OFS_P2L_DLY)
    begin
      d[6] = 1'b1;
    end
    return d;
  endfunction

  assign sel = decode(reg_addr);

  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : g_reg
      ipcfg_reg16 #(
        .MASK(MSK[g]),
        .RESET_VALUE(RST[g])
      ) u_reg (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .wr_en(reg_wr && sel[g]),
        .wr_data(reg_wdata),
        .value(val[g])
      );
    end
  endgenerate

  // read data path
  always_comb
  begin
    rdata_next = rdata_reg;
    hit_next = 1'b0;
    if (reg_rd)
    begin
      rdata_next = 16'h0000;
      hit_next = |sel;
      if (sel[0])
      begin
        rdata_next = val[0];
      end
      else if (sel[1])
      begin
        rdata_next = val[1];
      end
      else if (sel[2])
      begin
        rdata_next = val[2];
      end
      else if (sel[3])
      begin
        rdata_next = val[3];
      end
      else if (sel[4])
      begin
        rdata_next = val[4];
      end
      else if (sel[5])
      begin
        rdata_next = val[5];
      end
      else if (sel[6])
      begin
        rdata_next = val[6];
      end
    end
    else if (reg_wr)
    begin
      hit_next = |sel;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_reg <= 16'h0000;
      hit_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_hit = hit_reg;

  assign shared_cutoff_select = val[0][2:0];

  // pair one
  always_comb
  begin
    pair1_cfg.left_filter_on = val[1][BIT_FILTER_ON];
    pair1_cfg.oversample_rate = val[1][POS_OSR+:2];
    pair1_cfg.level_reference = val[1][POS_REF+:2];
    pair1_cfg.input_kind = ipcfg_kind_e'(val[1][POS_KIND+:2]);
    pair1_cfg.left_gain_code = val[1][POS_GAIN+:7];
    pair1_cfg.left_sample_delay = val[2][POS_DLY+:6];
    pair1_cfg.right_filter_on = val[3][BIT_FILTER_ON];
    pair1_cfg.right_gain_code = val[3][POS_GAIN+:7];
    pair1_cfg.right_sample_delay = val[4][POS_DLY+:6];
    pair1_cfg.left_is_digital = (pair1_cfg.input_kind == IPCFG_DMIC);
    pair1_cfg.right_is_digital = pair1_cfg.left_is_digital;
  end

  // pair two, right channel lives outside this bank
  always_comb
  begin
    pair2_cfg.left_filter_on = val[5][BIT_FILTER_ON];
    pair2_cfg.oversample_rate = val[5][POS_OSR+:2];
    pair2_cfg.level_reference = val[5][POS_REF+:2];
    pair2_cfg.input_kind = ipcfg_kind_e'(val[5][POS_KIND+:2]);
    pair2_cfg.left_gain_code = val[5][POS_GAIN+:7];
    pair2_cfg.left_sample_delay = val[6][POS_DLY+:6];
    pair2_cfg.right_filter_on = pair2_right_filter_gain_unused[0];
    pair2_cfg.right_gain_code = RST_RIGHT_CTL[POS_GAIN+:7];
    pair2_cfg.right_sample_delay = 6'h00;
    pair2_cfg.left_is_digital = (pair2_cfg.input_kind == IPCFG_DMIC);
    pair2_cfg.right_is_digital = pair2_cfg.left_is_digital;
  end

  // effective mic clock rate code
  assign pair1_clock_rate = pair1_noise_cancel_src ? OSR_FORCED
                            : pair1_cfg.oversample_rate;
  assign pair2_clock_rate = pair2_noise_cancel_src ? OSR_FORCED
                            : pair2_cfg.oversample_rate;
endmodule // ipcfg_regs

// [bench/ipcfg_host.sv]
// host model driving the control port
// assumes rising sys_clk sampling
`timescale 1ns/1ps
module ipcfg_host
  import ipcfg_pkg::*;
(
  // system
  input wire logic sys_clk,
  // control port
  output logic [9:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
  // write task holds reg_wr high for one sys_clk cycle
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule // ipcfg_host

// [bench/ipcfg_regs_sva.sv]
// checker for the config bank ports
// assumes bound to ipcfg_regs
`timescale 1ns/1ps
module ipcfg_regs_sva
  import ipcfg_pkg::*;
(
  // system
  input wire logic sys_clk,
  input wire logic reset_n,
  // control port
  input wire logic [IPCFG_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [IPCFG_DW-1:0] reg_wdata,
  input wire logic [IPCFG_DW-1:0] reg_rdata,
  input wire logic reg_hit,
  // noise cancel select and decoded
  input wire logic pair1_noise_cancel_src,
  input wire logic [2:0] shared_cutoff_select,
  input wire ipcfg_pair_s pair1_cfg,
  input wire ipcfg_pair_s pair2_cfg,
  input wire logic [1:0] pair1_clock_rate
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic map;
  assign map = reg_addr inside {OFS_CUTOFF, OFS_P1L_CTL, OFS_P1L_DLY,
    OFS_P1R_CTL, OFS_P1R_DLY, OFS_P2L_CTL, OFS_P2L_DLY};
  sequence acc_s;
    (reg_wr || reg_rd) && map;
  endsequence
  sequence wr_at(a);
    reg_wr && reg_addr == a;
  endsequence
  chk_hit_on: assert property (acc_s |=> reg_hit)
    else $error("hit missing");
  chk_hit_off: assert property (!((reg_wr || reg_rd) && map) |=>
    !reg_hit) else $error("stray hit");
  chk_unmap_zero: assert property (reg_rd && !map |=>
    reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_cut_write: assert property (wr_at(OFS_CUTOFF) |=>
    shared_cutoff_select == $past(reg_wdata[2:0])) else $error("cutoff");
  chk_left_write: assert property (wr_at(OFS_P1L_CTL) |=>
    {pair1_cfg.left_filter_on, pair1_cfg.oversample_rate,
    pair1_cfg.level_reference, pair1_cfg.input_kind, pair1_cfg.left_gain_code}
    == {$past(reg_wdata[15:9]), $past(reg_wdata[7:1])}) else $error("left");
  chk_right_write: assert property (wr_at(OFS_P1R_CTL) |=>
    {pair1_cfg.right_filter_on, pair1_cfg.right_gain_code}
    == {$past(reg_wdata[15]), $past(reg_wdata[7:1])}
    && $stable(pair1_cfg.oversample_rate)) else $error("right");
  chk_delay_write: assert property (wr_at(OFS_P2L_DLY) |=>
    pair2_cfg.left_sample_delay == $past(reg_wdata[5:0])) else $error("dly");
  chk_rate_forced: assert property (pair1_noise_cancel_src |->
    pair1_clock_rate == OSR_FORCED) else $error("forced rate");
  chk_rate_field: assert property (!pair1_noise_cancel_src |->
    pair1_clock_rate == pair1_cfg.oversample_rate) else $error("rate");
  chk_kind_both: assert property ({pair1_cfg.left_is_digital,
    pair1_cfg.right_is_digital} == {2{pair1_cfg.input_kind == IPCFG_DMIC}})
    else $error("kind");
endmodule // ipcfg_regs_sva
bind ipcfg_regs ipcfg_regs_sva ipcfg_regs_sva_i (.sys_clk, .reset_n,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_hit,
  .pair1_noise_cancel_src, .shared_cutoff_select, .pair1_cfg, .pair2_cfg,
  .pair1_clock_rate);

// [bench/ipcfg_regs_test.sv]
// self-checking bench for the config bank
// assumes ipcfg_host drives the port
`timescale 1ns/1ps
module ipcfg_regs_test
  import ipcfg_pkg::*;
;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic src1 = 1'h0;
  logic src2 = 1'h0;
  logic [9:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] v;
  logic reg_hit;
  logic [2:0] cut;
  logic [1:0] rate1;
  logic [1:0] rate2;
  ipcfg_pair_s p1;
  ipcfg_pair_s p2;
  int errors = 0;
  int check_count = 0;
  logic [9:0] ofs [8] = '{OFS_CUTOFF, OFS_P1L_CTL, OFS_P1L_DLY, OFS_P1R_CTL,
    OFS_P1R_DLY, OFS_P2L_CTL, OFS_P2L_DLY, 10'h30E};
  logic [15:0] rst [8] = '{16'h0002, 16'h2080, 16'h0, 16'h0080, 16'h0,
    16'h2080, 16'h0, 16'h0};
  logic [15:0] msk [8] = '{16'h0007, 16'hFEFE, 16'h003F, 16'h80FE,
    16'h003F, 16'hFEFE, 16'h003F, 16'h0};
  ipcfg_host ipcfg_host_i (.sys_clk, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata);
  ipcfg_regs ipcfg_regs_i (.sys_clk, .reset_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_hit, .pair1_noise_cancel_src(src1),
    .pair2_noise_cancel_src(src2), .pair2_right_filter_gain_unused(2'h0),
    .shared_cutoff_select(cut), .pair1_cfg(p1), .pair2_cfg(p2),
    .pair1_clock_rate(rate1), .pair2_clock_rate(rate2));
  initial forever #50 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 8; i++)
    begin
      ipcfg_host_i.rd(ofs[i], v);
      chk(v, rst[i]);
    end
  endtask
  task automatic t_mask();
    for (int i = 0; i < 8; i++)
    begin
      ipcfg_host_i.wr(ofs[i], 16'hFFFF);
      ipcfg_host_i.rd(ofs[i], v);
      chk(v, msk[i]);
      chk({15'h0, reg_hit}, {15'h0, i < 7});
    end
  endtask
  task automatic t_fields();
    for (int k = 0; k < 4; k++)
    begin
      v = {1'h1, k[1:0], k[1:0], k[1:0], 1'h0, 7'h40 + k[6:0], 1'h0};
      ipcfg_host_i.wr(OFS_P1L_CTL, v);
      ipcfg_host_i.wr(OFS_P2L_CTL, v);
      chk({p1.left_filter_on, p1.oversample_rate, p1.level_reference,
        p1.input_kind, 1'h0, p1.left_gain_code, 1'h0}, v);
      chk({p2.left_filter_on, p2.oversample_rate, p2.level_reference,
        p2.input_kind, 1'h0, p2.left_gain_code, 1'h0}, v);
      chk({12'h0, rate1, rate2}, {12'h0, v[14:13], v[14:13]});
      chk({14'h0, p1.left_is_digital, p1.right_is_digital},
        {14'h0, {2{k == 2}}});
      chk({14'h0, p2.left_is_digital, p2.right_is_digital},
        {14'h0, {2{k == 2}}});
      @(posedge sys_clk);
      src1 <= 1'h1;
      src2 <= 1'h1;
      @(posedge sys_clk);
      #1;
      chk({12'h0, rate1, rate2}, 16'h0005);
      @(posedge sys_clk);
      src1 <= 1'h0;
      src2 <= 1'h0;
    end
  endtask
  task automatic t_misc();
    for (int k = 0; k < 5; k++)
    begin
      ipcfg_host_i.wr(OFS_CUTOFF, 16'(k));
      chk({13'h0, cut}, 16'(k));
    end
    ipcfg_host_i.wr(OFS_P1R_DLY, 16'h002A);
    chk({10'h0, p1.right_sample_delay}, 16'h002A);
    ipcfg_host_i.wr(OFS_P1R_CTL, 16'hFFA5);
    chk({p1.right_filter_on, 8'h00, p1.right_gain_code}, 16'h8052);
    chk({14'h0, p1.oversample_rate}, 16'h0003);
    ipcfg_host_i.wr(OFS_P1L_DLY, 16'h00FF);
    chk({10'h0, p1.left_sample_delay}, 16'h003F);
    ipcfg_host_i.wr(OFS_P2L_DLY, 16'h0015);
    chk({10'h0, p2.left_sample_delay}, 16'h0015);
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'h1;
    t_reset();
    t_mask();
    t_fields();
    t_misc();
    results();
  end
  initial
  begin
    #1000000;
    errors++;
    results();
  end
endmodule // ipcfg_regs_test
